/* fixed_pwm.sv */
// fixed-period duty-programmable pwm generator, period 512 oscillator cycles
`timescale 1ns/10ps
module fixed_pwm (
  // clock and reset
  input  wire logic                       clk_i,
  input  wire logic                       rst_b_i,
  // duty setting from software
  input  wire logic [pwm_pkg::DUTY_W-1:0] duty_i,
  // pwm output
  output logic                            pwm_o
);
  import pwm_pkg::*;

  logic [FIXED_CNT_W-1:0] cnt;
  logic [DUTY_W-1:0]      duty_act;
  logic [DUTY_W-1:0]      next_duty;

  // duty in force next cycle: a new value only governs from the first cycle of a period,
  // otherwise the first cycle after the wrap would still follow the old duty (runt pulse)
  assign next_duty = (cnt == {FIXED_CNT_W{1'b1}}) ? duty_i : duty_act;

  // free-running 9-bit counter wraps every 512 cycles
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cnt <= '0;
    end else begin
      cnt <= cnt + 9'h001;
    end
  end

  // new duty only taken at the period wrap so no runt pulse appears
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      duty_act <= DUTY_RST;
    end else if (cnt == {FIXED_CNT_W{1'b1}}) begin
      duty_act <= duty_i;
    end
  end

  // high while count below duty; duty 0 never high, duty >= 512 always high
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      pwm_o <= 1'b0;
    end else begin
      pwm_o <= ({1'b0, next_cnt(cnt)} < next_duty) || (next_duty >= FIXED_PERIOD);
    end
  end

  function automatic logic [FIXED_CNT_W-1:0] next_cnt(input logic [FIXED_CNT_W-1:0] c);
    next_cnt = c + 9'h001;
  endfunction

endmodule

/* pwm_pkg.sv */
// package: register map, field layouts and timing constants of the triple pwm block
package pwm_pkg;

  // register offsets (word addresses on the plain register port)
  localparam logic [3:0] FIXED_PWM_A_DUTY_REG_OFS = 4'h0;
  localparam logic [3:0] FIXED_PWM_B_DUTY_REG_OFS = 4'h1;
  localparam logic [3:0] PROG_PWM_BASE_REG_OFS    = 4'h2;
  localparam logic [3:0] PROG_PWM_TIMING_REG_OFS  = 4'h3;
  localparam logic [3:0] PIN_ROUTE_REG_OFS        = 4'h4;
  localparam logic [3:0] PWM_STATUS_REG_OFS       = 4'h5;

  // field widths and positions
  localparam int DUTY_W      = 10;
  localparam int BASE_W      = 7;
  localparam int HL_W        = 8;
  localparam int HIGH_LSB    = 0;
  localparam int LOW_LSB     = 8;
  localparam int PIN_SEL_W   = 2;
  localparam int FIXED_CNT_W = 9;

  // reset values
  localparam logic [DUTY_W-1:0] DUTY_RST  = 10'h000;
  localparam logic [BASE_W-1:0] BASE_RST  = 7'h00;
  localparam logic [HL_W-1:0]   HL_RST    = 8'h00;

  // fixed generator period in oscillator cycles
  localparam logic [DUTY_W-1:0] FIXED_PERIOD = 10'h200;

  // pin source selector codes
  localparam logic [PIN_SEL_W-1:0] SEL_OFF   = 2'h0;
  localparam logic [PIN_SEL_W-1:0] SEL_FIX_A = 2'h1;
  localparam logic [PIN_SEL_W-1:0] SEL_FIX_B = 2'h2;
  localparam logic [PIN_SEL_W-1:0] SEL_PROG  = 2'h3;

  typedef struct packed {
    logic [3:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } reg_req_type;

  typedef enum logic [1:0] {
    PROG_HIGH = 2'b01,
    PROG_LOW  = 2'b10
  } prog_state_type;

endpackage

/* tb.sv */
// self-checking testbench for the triple pwm block
`timescale 1ns/10ps
module tb;
  import pwm_pkg::*;
  logic ref_clk = 1'b0;
  logic rst_b = 1'b0;
  logic [3:0] addr = 4'h0;
  logic [31:0] wdata = 32'h0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [31:0] rdata;
  logic pwm_a, pwm_b, pwm_prog;
  logic [3:0] gp_pin;
  int err_count = 0;
  int total_checks = 0;
  int seed = 32'h1bf7daec;
  triple_general_pwm uut (.REF_CLK_I(ref_clk), .RST_B_I(rst_b), .ADDR_I(addr),
    .WDATA_I(wdata), .WR_I(wr), .RD_I(rd), .RDATA_O(rdata), .PWM_A_O(pwm_a),
    .PWM_B_O(pwm_b), .PWM_PROG_O(pwm_prog), .GP_PIN_O(gp_pin));
  initial forever #5 ref_clk = ~ref_clk;
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge ref_clk);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [3:0] a, output logic [31:0] d);
    @(posedge ref_clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge ref_clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask
  task automatic count_high(input int which, input int len, output int n);
    n = 0;
    repeat (len) begin
      @(posedge ref_clk);
      #1 n += ((which == 0) ? pwm_a : (which == 1) ? pwm_b : pwm_prog) === 1'b1;
    end
  endtask
  task automatic give_verdict;
    $display("checks %0d errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  initial begin
    #400_000;
    err_count++;
    give_verdict();
  end
  initial begin
    int n, p, b, h, l, sel;
    logic [31:0] d, v;
    int duty[6] = '{0, 1, 255, 511, 512, 1023};
    int mask[5] = '{32'h3FF, 32'h3FF, 32'h7F, 32'hFFFF, 32'hFF};
    int pb[6] = '{0, 2, 4, 1, 3, 0};
    int ph[6] = '{3, 1, 0, 0, 6, 200};
    int pl[6] = '{5, 1, 0, 7, 0, 1};
    repeat (12) @(posedge ref_clk);
    rst_b <= 1'b1;
    // every place reads zero after reset, unmapped ones always
    for (int a = 0; a < 16; a++) begin
      rd_reg(a[3:0], d);
      check(d, 32'h0);
    end
    for (int a = 0; a < 5; a++) begin
      v = $random(seed);
      wr_reg(a[3:0], v);
      rd_reg(a[3:0], d);
      check(d, v & mask[a]);
    end
    // a reset in mid-run drops the random settings, so later periods start from idle
    @(posedge ref_clk);
    rst_b <= 1'b0;
    repeat (3) @(posedge ref_clk);
    #1 check({pwm_a, pwm_b, pwm_prog, gp_pin}, 32'h0);
    @(posedge ref_clk);
    rst_b <= 1'b1;
    for (int a = 0; a < 5; a++) begin
      rd_reg(a[3:0], d);
      check(d, 32'h0);
    end
    foreach (duty[i]) begin
      p = $random(seed) & 32'h1FF;
      wr_reg(FIXED_PWM_A_DUTY_REG_OFS, duty[i]);
      wr_reg(FIXED_PWM_B_DUTY_REG_OFS, p);
      // new duty waits for the period wrap, so let two periods pass
      repeat (1100) @(posedge ref_clk);
      count_high(0, 512, n);
      check(n, (duty[i] > 512) ? 512 : duty[i]);
      count_high(1, 512, n);
      check(n, p);
    end
    p = 512;
    for (int i = 0; i < 9; i++) begin
      b = (i < 6) ? pb[i] : $random(seed) & 3;
      h = (i < 6) ? ph[i] : $random(seed) & 15;
      l = (i < 6) ? pl[i] : $random(seed) & 15;
      wr_reg(PROG_PWM_BASE_REG_OFS, b);
      wr_reg(PROG_PWM_TIMING_REG_OFS, (l << 8) | h);
      n = (b + 1) * (h + l);
      // base and counts may land in different cycles of the old setting
      repeat (4 * p + 2 * n + 40) @(posedge ref_clk);
      p = (n == 0) ? 64 : n;
      count_high(2, p, n);
      check(n, (b + 1) * h);
    end
    wr_reg(PROG_PWM_TIMING_REG_OFS, 32'h0302);
    wr_reg(FIXED_PWM_A_DUTY_REG_OFS, 32'h64);
    for (int k = 0; k < 2; k++) begin
      v = (k == 0) ? 32'hE4 : $random(seed) & 32'hFF;
      wr_reg(PIN_ROUTE_REG_OFS, v);
      repeat (3) @(posedge ref_clk);
      repeat (600) begin
        @(posedge ref_clk);
        #1;
        for (int j = 0; j < 4; j++) begin
          sel = (v >> (2 * j)) & 3;
          d = (sel == 1) ? pwm_a : (sel == 2) ? pwm_b : (sel == 3) ? pwm_prog : 1'b0;
          check(gp_pin[j], d);
        end
      end
    end
    give_verdict();
  end
endmodule

/* triple_general_pwm.sv */
// triple general-purpose pwm block with register port and pin routing
`timescale 1ns/10ps
// Contract
// - three independent generators: two fixed-period, one programmable.
// - fixed generators have a period of 512 oscillator cycles.
// - fixed generator high time equals its 10-bit duty value in cycles; the code caps it at 512 cycles (always high) for values above 512.
// - fixed generator duty zero keeps output low all period.
// - programmable base tick period is base field plus one cycles.
// - programmable output high for high count ticks, then low count ticks.
// - programmable high and low both zero forces output low.
// - each generator output is selectable as source for general-purpose pins.
module triple_general_pwm #(
  parameter int PIN_N = 4
) (
  // clock and reset
  input  wire logic                 REF_CLK_I,
  input  wire logic                 RST_B_I,
  // register port
  input  wire logic [3:0]           ADDR_I,
  input  wire logic [31:0]          WDATA_I,
  input  wire logic                 WR_I,
  input  wire logic                 RD_I,
  output logic [31:0]               RDATA_O,
  // pwm signals
  output logic                      PWM_A_O,
  output logic                      PWM_B_O,
  output logic                      PWM_PROG_O,
  output logic [PIN_N-1:0]          GP_PIN_O
);
  import pwm_pkg::*;

  reg_req_type req;
  assign req = '{addr: ADDR_I, wdata: WDATA_I, wr: WR_I, rd: RD_I};

  logic [DUTY_W-1:0]        fixed_pwm_a_duty_reg;
  logic [DUTY_W-1:0]        fixed_pwm_b_duty_reg;
  logic [BASE_W-1:0]        prog_pwm_base_divider;
  logic [HL_W-1:0]          prog_pwm_high_count;
  logic [HL_W-1:0]          prog_pwm_low_count;
  logic [2*PIN_N-1:0]       pin_route;
  logic                     fix_a;
  logic                     fix_b;
  logic [BASE_W-1:0]        base_act;
  logic [HL_W-1:0]          high_act;
  logic [HL_W-1:0]          low_act;
  logic [BASE_W-1:0]        base_cnt;
  logic [HL_W-1:0]          lvl_cnt;
  logic                     tick;
  logic                     prog_out;
  logic                     next_prog_out;
  prog_state_type           state;
  prog_state_type           next_state;
  logic [HL_W-1:0]          next_lvl_cnt;
  logic                     period_end;

  // register writes
  always_ff @(posedge REF_CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      fixed_pwm_a_duty_reg  <= DUTY_RST;
      fixed_pwm_b_duty_reg  <= DUTY_RST;
      prog_pwm_base_divider <= BASE_RST;
      prog_pwm_high_count   <= HL_RST;
      prog_pwm_low_count    <= HL_RST;
      pin_route             <= '0;
    end else if (req.wr) begin
      case (req.addr)
        FIXED_PWM_A_DUTY_REG_OFS: fixed_pwm_a_duty_reg <= req.wdata[DUTY_W-1:0];
        FIXED_PWM_B_DUTY_REG_OFS: fixed_pwm_b_duty_reg <= req.wdata[DUTY_W-1:0];
        PROG_PWM_BASE_REG_OFS:    prog_pwm_base_divider <= req.wdata[BASE_W-1:0];
        PROG_PWM_TIMING_REG_OFS: begin
          prog_pwm_high_count <= req.wdata[HIGH_LSB +: HL_W];
          prog_pwm_low_count  <= req.wdata[LOW_LSB +: HL_W];
        end
        PIN_ROUTE_REG_OFS:        pin_route <= req.wdata[2*PIN_N-1:0];
        default: ;
      endcase
    end
  end

  // read data stands one cycle after the read strobe; unmapped reads give zero
  always_ff @(posedge REF_CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      RDATA_O <= '0;
    end else if (req.rd) begin
      case (req.addr)
        FIXED_PWM_A_DUTY_REG_OFS: RDATA_O <= 32'(fixed_pwm_a_duty_reg);
        FIXED_PWM_B_DUTY_REG_OFS: RDATA_O <= 32'(fixed_pwm_b_duty_reg);
        PROG_PWM_BASE_REG_OFS:    RDATA_O <= 32'(prog_pwm_base_divider);
        PROG_PWM_TIMING_REG_OFS:  RDATA_O <= {16'h0000, prog_pwm_low_count, prog_pwm_high_count};
        PIN_ROUTE_REG_OFS:        RDATA_O <= 32'(pin_route);
        PWM_STATUS_REG_OFS:       RDATA_O <= {29'h00000000, prog_out, fix_b, fix_a};
        default:                  RDATA_O <= '0;
      endcase
    end else begin
      RDATA_O <= '0;
    end
  end

  // two fixed generators share one module, each its own counter
  fixed_pwm u_fix_a (
    .clk_i   (REF_CLK_I),
    .rst_b_i (RST_B_I),
    .duty_i  (fixed_pwm_a_duty_reg),
    .pwm_o   (fix_a)
  );

  fixed_pwm u_fix_b (
    .clk_i   (REF_CLK_I),
    .rst_b_i (RST_B_I),
    .duty_i  (fixed_pwm_b_duty_reg),
    .pwm_o   (fix_b)
  );

  // base tick prescaler: one tick every base+1 cycles
  assign tick = (base_cnt == base_act);

  always_ff @(posedge REF_CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      base_cnt <= '0;
    end else if (tick) begin
      base_cnt <= '0;
    end else begin
      base_cnt <= base_cnt + 7'h01;
    end
  end

  // a period ends on the tick closing its low phase, or closing the high phase when there
  // is no low phase, so a zero low count keeps the output high with no one-tick dip
  assign period_end = tick && (lvl_cnt <= 8'h01) &&
                      (state == PROG_LOW || low_act == '0);

  // settings latched only at the period end so the running pulse is never cut
  always_ff @(posedge REF_CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      base_act <= BASE_RST;
      high_act <= HL_RST;
      low_act  <= HL_RST;
    end else if (period_end) begin
      base_act <= prog_pwm_base_divider;
      high_act <= prog_pwm_high_count;
      low_act  <= prog_pwm_low_count;
    end
  end

  // phase sequencer: high for high ticks, then low for low ticks; zero-length phases skip
  always_comb begin
    next_state    = state;
    next_lvl_cnt  = lvl_cnt;
    next_prog_out = prog_out;
    if (period_end) begin
      if (prog_pwm_high_count != '0) begin
        next_state    = PROG_HIGH;
        next_lvl_cnt  = prog_pwm_high_count;
        next_prog_out = 1'b1;
      end else begin
        next_state    = PROG_LOW;
        next_lvl_cnt  = prog_pwm_low_count;
        next_prog_out = 1'b0;
      end
    end else if (tick) begin
      case (state)
        PROG_HIGH: begin
          if (lvl_cnt > 8'h01) begin
            next_lvl_cnt = lvl_cnt - 8'h01;
          end else begin
            next_state    = PROG_LOW;
            next_lvl_cnt  = low_act;
            next_prog_out = 1'b0;
          end
        end
        PROG_LOW: begin
          next_lvl_cnt = lvl_cnt - 8'h01;
        end
        default: begin
          next_state    = PROG_LOW;
          next_prog_out = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge REF_CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      state    <= PROG_LOW;
      lvl_cnt  <= '0;
      prog_out <= 1'b0;
    end else begin
      state    <= next_state;
      lvl_cnt  <= next_lvl_cnt;
      prog_out <= next_prog_out;
    end
  end

  // outputs registered again so every port comes from a flop
  always_ff @(posedge REF_CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      PWM_A_O    <= 1'b0;
      PWM_B_O    <= 1'b0;
      PWM_PROG_O <= 1'b0;
    end else begin
      PWM_A_O    <= fix_a;
      PWM_B_O    <= fix_b;
      PWM_PROG_O <= prog_out;
    end
  end

  // per-pin source selector
  genvar gi;
  generate
    for (gi = 0; gi < PIN_N; gi++) begin : g_pin
      always_ff @(posedge REF_CLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
          GP_PIN_O[gi] <= 1'b0;
        end else begin
          case (pin_route[2*gi +: 2])
            SEL_FIX_A: GP_PIN_O[gi] <= fix_a;
            SEL_FIX_B: GP_PIN_O[gi] <= fix_b;
            SEL_PROG:  GP_PIN_O[gi] <= prog_out;
            default:   GP_PIN_O[gi] <= 1'b0;
          endcase
        end
      end
    end
  endgenerate

endmodule

/* triple_general_pwm_checker.sv */
// assertion checker for the triple pwm block
`timescale 1ns/10ps
module triple_general_pwm_checker
  import pwm_pkg::*;
#(
  parameter int PIN_N = 4
) (
  // clock and reset
  input wire logic             REF_CLK_I,
  input wire logic             RST_B_I,
  // register port
  input wire logic [3:0]       ADDR_I,
  input wire logic             RD_I,
  input wire logic [31:0]      RDATA_O,
  // pwm signals
  input wire logic             PWM_A_O,
  input wire logic             PWM_B_O,
  input wire logic             PWM_PROG_O,
  input wire logic [PIN_N-1:0] GP_PIN_O
);
  logic [1:0] prev;
  logic [1:0] seen;
  logic [1:0] rise;
  logic [8:0] gap_a;
  logic [8:0] gap_b;
  assign rise = {PWM_B_O, PWM_A_O} & ~prev;
  // cycles since the last rising edge; wraps with the 512-cycle period
  always_ff @(posedge REF_CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      prev <= 2'h0;
      seen <= 2'h0;
      gap_a <= 9'h000;
      gap_b <= 9'h000;
    end else begin
      prev <= {PWM_B_O, PWM_A_O};
      seen <= seen | rise;
      gap_a <= rise[0] ? 9'h000 : gap_a + 9'h001;
      gap_b <= rise[1] ? 9'h000 : gap_b + 9'h001;
    end
  end
  default clocking @(posedge REF_CLK_I); endclocking
  default disable iff (!RST_B_I);
  sequence read_cycle;
    RD_I ##1 1'b1;
  endsequence
  chk_read_idle: assert property (!$past(RD_I) |-> RDATA_O == 32'h0)
    else $error("read data not zero outside read answer");
  chk_read_upper: assert property (read_cycle |-> RDATA_O[31:16] == 16'h0)
    else $error("upper read data bits not zero");
  chk_read_unmapped: assert property (RD_I && ADDR_I > PWM_STATUS_REG_OFS |=> RDATA_O == 32'h0)
    else $error("unmapped read not zero");
  chk_status_mirror: assert property (RD_I && ADDR_I == PWM_STATUS_REG_OFS
    |=> RDATA_O[2:0] == {PWM_PROG_O, PWM_B_O, PWM_A_O})
    else $error("status bits differ from outputs");
  chk_pin_source: assert property ((GP_PIN_O & ~({PIN_N{PWM_A_O}} | {PIN_N{PWM_B_O}}
    | {PIN_N{PWM_PROG_O}})) == '0)
    else $error("pin high with no high source");
  chk_a_period: assert property (seen[0] && rise[0] |-> gap_a == 9'h1FF)
    else $error("fixed A rise off the period grid");
  chk_b_period: assert property (seen[1] && rise[1] |-> gap_b == 9'h1FF)
    else $error("fixed B rise off the period grid");
  chk_reset_quiet: assert property ($rose(RST_B_I) |->
    !(PWM_A_O || PWM_B_O || PWM_PROG_O) && GP_PIN_O == '0)
    else $error("output high right after reset");
endmodule
bind triple_general_pwm triple_general_pwm_checker #(.PIN_N(PIN_N)) u_chk (
  .REF_CLK_I(REF_CLK_I), .RST_B_I(RST_B_I), .ADDR_I(ADDR_I), .RD_I(RD_I),
  .RDATA_O(RDATA_O), .PWM_A_O(PWM_A_O), .PWM_B_O(PWM_B_O),
  .PWM_PROG_O(PWM_PROG_O), .GP_PIN_O(GP_PIN_O));
